/* File: fip_flash_isp_call_interface.sv */
// fip_flash_isp_call_interface: apb register file and boot call sequencer.
// assumes a flash port that acks each command with a one-cycle pulse and a
// ram port whose read data is valid the cycle after the address is given.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module fip_flash_isp_call_interface
    import fip_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // cpu side
    input wire logic serial_isp_i,
    input wire logic security_i,
    input wire logic irq_taken_i,
    input wire logic [7:0] irq_req_i,
    output logic irq_block_o,
    output logic [7:0] irq_o,
    // flash port
    output fip_flash_cmd_type flash_cmd_o,
    output logic [15:0] flash_addr_o,
    output logic [7:0] flash_wdata_o,
    output logic [7:0] flash_timing_o,
    input wire logic [7:0] flash_rdata_i,
    input wire logic flash_ack_i,
    // ram port for block transfers
    output logic [7:0] ram_addr_o,
    output logic [7:0] ram_wdata_o,
    output logic ram_we_o,
    input wire logic [7:0] ram_rdata_i,
    // watchdog
    output logic wdt_service_o,
    output logic wdt_lower_en_o
);

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta, rst_n;

    // two stages so release never lands near an edge of the core logic
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
        hit = (a[11:2] == idx) && (a[1:0] == 2'b00);
    endfunction : hit

    logic [7:0] addr_lo, addr_hi, result, wvalue, timing, key, count, accum, xptr;
    logic refused, sec_block;
    fip_state_type state;
    wire busy = (state != S_IDLE);
    wire key_valid;

    wire wr_go = psel_i && penable_i && pwrite_i;
    wire setup_rd = psel_i && !penable_i && !pwrite_i;
    wire [7:0] wbyte = pwdata_i[7:0];
    wire h_lo = hit(paddr_i, IDX_ADDR_LO);
    wire h_hi = hit(paddr_i, IDX_ADDR_HI);
    wire h_res = hit(paddr_i, IDX_RESULT);
    wire h_wv = hit(paddr_i, IDX_WVALUE);
    wire h_tim = hit(paddr_i, IDX_TIMING);
    wire h_key = hit(paddr_i, IDX_KEY);
    wire h_cnt = hit(paddr_i, IDX_COUNT);
    wire h_call = hit(paddr_i, IDX_CALL);
    wire h_acc = hit(paddr_i, IDX_ACCUM);
    wire h_xp = hit(paddr_i, IDX_XPTR);
    wire h_st = hit(paddr_i, IDX_STATUS);
    wire mapped = h_lo | h_hi | h_res | h_wv | h_tim | h_key | h_cnt | h_call | h_acc
                  | h_xp | h_st;
    wire [7:0] status = {4'h0, sec_block, refused, key_valid, busy};

    // read data selected here, captured in the setup cycle
    wire [7:0] rd_sel = h_lo ? addr_lo : h_hi ? addr_hi : h_res ? result :
                        h_wv ? wvalue : h_tim ? timing : h_key ? key :
                        h_cnt ? count : h_acc ? accum : h_xp ? xptr :
                        h_st ? status : REG_RESET;

    assign pready_o = 1'b1; // zero wait states
    assign pslverr_o = psel_i && penable_i && !mapped;

    // read data register, reads have no side effects
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            prdata_o <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata_o <= {24'h00_0000, rd_sel};
        end
    end

    // ----------------------------------------------------------------
    // call acceptance
    // ----------------------------------------------------------------
    wire call_go = wr_go && h_call;
    wire [7:0] ep = wbyte;
    wire ep_known = (ep == EP_PAGE_ERASE) || (ep == EP_MASS_ERASE) ||
                    (ep == EP_READ_BYTE) || (ep == EP_BLOCK_READ) ||
                    (ep == EP_WRITE_BYTE) || (ep == EP_BLOCK_WRITE);
    wire key_fail = !serial_isp_i && !key_valid;
    wire sec_fail = serial_isp_i && security_i && (ep != EP_MASS_ERASE);
    wire conf_fail = (ep == EP_MASS_ERASE) && (accum != ERASE_CONFIRM);
    wire accept = call_go && !busy && ep_known && !key_fail && !sec_fail && !conf_fail;
    wire reject = call_go && !accept;
    wire is_block = (ep == EP_BLOCK_READ) || (ep == EP_BLOCK_WRITE);

    fip_key_guard u_key_guard (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .key_load_i(wr_go && h_key),
        .key_value_i(wbyte),
        .irq_taken_i(irq_taken_i),
        .call_i(call_go),
        .key_valid_o(key_valid)
    );

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    // sticky flags: a new refusal beats a write-one-to-clear in the same cycle
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wvalue <= REG_RESET;
            timing <= REG_RESET;
            key <= REG_RESET;
            count <= REG_RESET;
            accum <= REG_RESET;
            xptr <= REG_RESET;
            refused <= 1'b0;
            sec_block <= 1'b0;
        end else begin
            if (wr_go && h_wv) wvalue <= wbyte;
            if (wr_go && h_tim) timing <= wbyte;
            if (wr_go && h_key) key <= wbyte;
            if (wr_go && h_cnt) count <= wbyte;
            if (wr_go && h_acc) accum <= wbyte;
            if (wr_go && h_xp) xptr <= wbyte;
            if (wr_go && h_st && wbyte[ST_REFUSED]) refused <= 1'b0;
            if (wr_go && h_st && wbyte[ST_SEC_BLOCK]) sec_block <= 1'b0;
            if (reject) refused <= 1'b1;
            if (call_go && sec_fail) sec_block <= 1'b1;
        end
    end

    assign flash_timing_o = timing;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    logic [7:0] op, left, rptr;
    // flash address and result share the bus write path with the sequencer
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_IDLE;
            op <= REG_RESET;
            left <= REG_RESET;
            rptr <= REG_RESET;
            addr_lo <= REG_RESET;
            addr_hi <= REG_RESET;
            result <= REG_RESET;
            flash_cmd_o <= '0;
            flash_addr_o <= 16'h0000;
            flash_wdata_o <= REG_RESET;
            ram_addr_o <= REG_RESET;
            ram_wdata_o <= REG_RESET;
            ram_we_o <= 1'b0;
        end else begin
            if (wr_go && h_lo && !busy) addr_lo <= wbyte;
            if (wr_go && h_hi && !busy) addr_hi <= wbyte;
            if (wr_go && h_res && !busy) result <= wbyte;
            ram_we_o <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (accept) begin
                        op <= ep;
                        left <= count;
                        rptr <= xptr;
                        ram_addr_o <= xptr;
                        flash_addr_o <= {addr_hi, addr_lo};
                        flash_wdata_o <= wvalue;
                        if (is_block && (count == 8'h00)) begin
                            state <= S_DONE;
                        end else if (ep == EP_BLOCK_WRITE) begin
                            state <= S_FETCH;
                        end else begin
                            flash_cmd_o.rd <= (ep == EP_READ_BYTE) || (ep == EP_BLOCK_READ);
                            flash_cmd_o.wr <= (ep == EP_WRITE_BYTE);
                            flash_cmd_o.erase_page <= (ep == EP_PAGE_ERASE);
                            flash_cmd_o.erase_all <= (ep == EP_MASS_ERASE);
                            state <= S_FLASH;
                        end
                    end
                end
                S_FETCH: begin
                    state <= S_LATCH; // ram samples the pointer here
                end
                S_LATCH: begin
                    flash_wdata_o <= ram_rdata_i;
                    flash_cmd_o.wr <= 1'b1;
                    state <= S_FLASH;
                end
                S_FLASH: begin
                    if (flash_ack_i) begin
                        flash_cmd_o <= '0;
                        if (op == EP_READ_BYTE) begin
                            result <= flash_rdata_i;
                            state <= S_DONE;
                        end else if (op == EP_BLOCK_READ) begin
                            ram_wdata_o <= flash_rdata_i;
                            ram_we_o <= 1'b1;
                            state <= S_STORE;
                        end else if ((op == EP_BLOCK_WRITE) && (left != 8'h01)) begin
                            left <= left - 8'h01;
                            flash_addr_o <= flash_addr_o + 16'h0001;
                            rptr <= rptr + 8'h01;
                            ram_addr_o <= rptr + 8'h01;
                            state <= S_FETCH;
                        end else begin
                            state <= S_DONE;
                        end
                    end
                end
                S_STORE: begin
                    if (left == 8'h01) begin
                        state <= S_DONE;
                    end else begin
                        left <= left - 8'h01;
                        flash_addr_o <= flash_addr_o + 16'h0001;
                        rptr <= rptr + 8'h01;
                        ram_addr_o <= rptr + 8'h01;
                        flash_cmd_o.rd <= 1'b1;
                        state <= S_FLASH;
                    end
                end
                S_DONE: begin
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // interrupt hold-off
    // ----------------------------------------------------------------
    logic [7:0] held;

    // held requests are one bit per source, so repeats merge; the global
    // enable stays with the cpu and decides when the replayed ones are taken
    assign irq_block_o = busy;

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            held <= 8'h00;
            irq_o <= 8'h00;
        end else if (busy) begin
            held <= held | irq_req_i;
            irq_o <= 8'h00;
        end else begin
            held <= 8'h00;
            irq_o <= held | irq_req_i;
        end
    end

    // ----------------------------------------------------------------
    // watchdog servicing
    // ----------------------------------------------------------------
    logic [11:0] wdt_cnt;
    wire wdt_due = busy && (wdt_cnt == WDT_SERVICE_CYCLES - 12'h001);

    // periodic kick while busy, then one more kick plus lower window on exit
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wdt_cnt <= 12'h000;
            wdt_service_o <= 1'b0;
            wdt_lower_en_o <= 1'b0;
        end else begin
            wdt_cnt <= (!busy || wdt_due) ? 12'h000 : wdt_cnt + 12'h001;
            wdt_service_o <= wdt_due || (state == S_DONE);
            wdt_lower_en_o <= (state == S_DONE);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_addr_load: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        accept |=> flash_addr_o == {$past(addr_hi), $past(addr_lo)})
        else $error("flash address not taken from address bytes");
    a_read_result: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (state == S_FLASH && op == EP_READ_BYTE && flash_ack_i)
        |=> result == $past(flash_rdata_i) ##1 state == S_IDLE)
        else $error("read byte result not stored");
    a_count_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (accept && is_block && count == 8'h00)
        |=> state == S_DONE && flash_cmd_o == '0)
        else $error("empty block transfer touched flash");
    a_irq_blocked: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (busy && $past(busy)) |-> irq_o == 8'h00)
        else $error("interrupt forwarded during routine");
    // a repeated request must land in the same held bit, never queue up
    a_irq_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        busy |=> (held & $past(irq_req_i)) == $past(irq_req_i))
        else $error("request during routine not held");
    a_irq_replay: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (!busy && $past(busy)) |=> (irq_o & $past(held)) == $past(held))
        else $error("held interrupt not replayed");
    a_sec_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (call_go && !busy && serial_isp_i && security_i && ep != EP_MASS_ERASE)
        |=> state == S_IDLE && refused && sec_block)
        else $error("secured serial command executed");
    a_user_nosec: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (call_go && !busy && !serial_isp_i && key_valid && security_i && ep_known
         && ep != EP_MASS_ERASE) |=> state != S_IDLE)
        else $error("user call blocked by security");
    a_wdt_exit: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        state == S_DONE |=> wdt_service_o && wdt_lower_en_o ##1 !wdt_lower_en_o)
        else $error("watchdog not serviced on exit");
    a_call_refused: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (call_go && !busy && !serial_isp_i && !key_valid)
        |=> state == S_IDLE && refused)
        else $error("call without key was accepted");

endmodule : fip_flash_isp_call_interface
`default_nettype wire

/* File: fip_pkg.sv */
// fip_pkg: constants and types for the flash call interface block.
// assumes a 50 MHz core clock where one clock equals one instruction cycle.
package fip_pkg;

    // ----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [9:0] IDX_ADDR_LO = 10'h0a8;
    localparam logic [9:0] IDX_ADDR_HI = 10'h0a9;
    localparam logic [9:0] IDX_RESULT = 10'h0aa;
    localparam logic [9:0] IDX_WVALUE = 10'h0ab;
    localparam logic [9:0] IDX_TIMING = 10'h0e1;
    localparam logic [9:0] IDX_KEY = 10'h0e2;
    localparam logic [9:0] IDX_COUNT = 10'h0f1;
    localparam logic [9:0] IDX_CALL = 10'h0c0;
    localparam logic [9:0] IDX_ACCUM = 10'h0c1;
    localparam logic [9:0] IDX_XPTR = 10'h0c2;
    localparam logic [9:0] IDX_STATUS = 10'h0c3;

    // ----------------------------------------------------------------
    // status fields, keys, entry points
    // ----------------------------------------------------------------
    localparam int ST_BUSY = 0;
    localparam int ST_KEY_OK = 1;
    localparam int ST_REFUSED = 2;
    localparam int ST_SEC_BLOCK = 3;
    localparam logic [7:0] UNLOCK_VALUE = 8'h98;
    localparam logic [7:0] ERASE_CONFIRM = 8'h55;
    localparam logic [7:0] EP_PAGE_ERASE = 8'h17;
    localparam logic [7:0] EP_MASS_ERASE = 8'h1a;
    localparam logic [7:0] EP_READ_BYTE = 8'h11;
    localparam logic [7:0] EP_BLOCK_READ = 8'h26;
    localparam logic [7:0] EP_WRITE_BYTE = 8'h14;
    localparam logic [7:0] EP_BLOCK_WRITE = 8'h23;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int KEY_WINDOW_INSTR = 6;
    localparam logic [2:0] KEY_WINDOW_CYCLES = 3'(KEY_WINDOW_INSTR);
    localparam int WDT_SERVICE_US = 20;
    localparam logic [11:0] WDT_SERVICE_CYCLES = 12'(WDT_SERVICE_US * (CLK_HZ / 1_000_000));

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic erase_all;
        logic erase_page;
        logic wr;
        logic rd;
    } fip_flash_cmd_type;

    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_FETCH = 6'b000010,
        S_LATCH = 6'b000100,
        S_FLASH = 6'b001000,
        S_STORE = 6'b010000,
        S_DONE = 6'b100000
    } fip_state_type;

endpackage : fip_pkg

/* File: fip_key_guard.sv */
// fip_key_guard: arms the call window when the correct key is loaded.
// assumes key_load_i, irq_taken_i and call_i are single-cycle pulses.
`timescale 1ns/100ps
`default_nettype none
module fip_key_guard
    import fip_pkg::*;
(
    // clock and synchronised reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // events
    input wire logic key_load_i,
    input wire logic [7:0] key_value_i,
    input wire logic irq_taken_i,
    input wire logic call_i,
    // window state
    output logic key_valid_o
);

    // ----------------------------------------------------------------
    // window countdown
    // ----------------------------------------------------------------
    logic [2:0] left;
    logic [2:0] next_left;
    wire key_good = key_load_i && (key_value_i == UNLOCK_VALUE);

    // a fresh good key re-arms even in a cycle where the old one dies
    always_comb begin
        next_left = left;
        if (left != 3'h0) begin
            next_left = left - 3'h1;
        end
        if (irq_taken_i || call_i || (key_load_i && !key_good)) begin
            next_left = 3'h0;
        end
        if (key_good) begin
            next_left = KEY_WINDOW_CYCLES;
        end
    end

    // counter register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            left <= 3'h0;
        end else begin
            left <= next_left;
        end
    end

    assign key_valid_o = (left != 3'h0);

    // expiry after a serviced interrupt must be seen at the next cycle
    a_key_expire: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (irq_taken_i && !key_load_i) |=> !key_valid_o)
        else $error("key still valid after interrupt");

    // a good key stays usable for exactly the window and no longer
    a_key_window: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (key_good ##1 (!key_load_i && !irq_taken_i && !call_i) [*6])
        |=> !key_valid_o)
        else $error("key window length wrong");

endmodule : fip_key_guard
`default_nettype wire

/* File: fip_flash_model.sv */
// fip_flash_model: flash responder (read data is address high xor low) and data ram behind the sequencer.
// assumes commands are held until acked.
`timescale 1ns/100ps
`default_nettype none
module fip_flash_model
    import fip_pkg::*;
(
    // clock
    input wire logic clk_i,
    // flash and ram ports
    input wire fip_flash_cmd_type cmd_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] timing_i,
    input wire logic [7:0] ram_addr_i,
    input wire logic [7:0] ram_wdata_i,
    input wire logic ram_we_i,
    output logic [7:0] rdata_o = 8'h00,
    output logic ack_o = 1'b0,
    output logic [7:0] ram_rdata_o = 8'h00
);
    logic [7:0] mem [256];
    logic [15:0] last_addr = 16'h0000;
    logic [7:0] last_wdata = 8'h00;
    logic [7:0] last_timing = 8'h00;
    int ops = 0;
    int wait_n = 0;
    // odd addresses ack on the second command cycle, even ones on the sixth; idle bus toggles
    always @(posedge clk_i) begin
        ack_o <= 1'b0;
        rdata_o <= ~rdata_o;
        ram_rdata_o <= mem[ram_addr_i];
        if (ram_we_i) begin
            mem[ram_addr_i] <= ram_wdata_i;
        end
        if (cmd_i != 4'h0 && !ack_o) begin
            if (wait_n == 0) begin
                ops++;
                last_addr <= addr_i;
                last_wdata <= wdata_i;
                last_timing <= timing_i;
            end
            wait_n++;
            if (wait_n > (addr_i[0] ? 1 : 5)) begin
                ack_o <= 1'b1;
                rdata_o <= addr_i[15:8] ^ addr_i[7:0];
                wait_n = 0;
            end
        end
    end
endmodule : fip_flash_model
`default_nettype wire

/* File: test_flash_isp_call_interface.sv */
// test_flash_isp_call_interface: self-checking bench over apb.
// assumes fip_flash_model stands on the flash and ram ports.
`timescale 1ns/100ps
`default_nettype none
module test_flash_isp_call_interface;
    import fip_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, ser = 0, sec = 0, irqt = 0;
    logic [11:0] pa = 0;
    logic [31:0] pwd = 0, r, prd;
    logic [7:0] irq = 0, irqo, fwd, ftim, frd, ra, rwd, rrd;
    logic prdy, perr, e, blk, fack, rwe, wdt, wlo;
    logic [15:0] fa;
    fip_flash_cmd_type fcmd;
    int bad_count = 0, checks = 0, cyc = 0, irq_n = 0, lo_n = 0, wd_n = 0;
    fip_flash_isp_call_interface uut (.ref_clk_i(clk), .reset_n_i(rst_n), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
        .pready_o(prdy), .pslverr_o(perr), .serial_isp_i(ser), .security_i(sec),
        .irq_taken_i(irqt), .irq_req_i(irq), .irq_block_o(blk), .irq_o(irqo),
        .flash_cmd_o(fcmd), .flash_addr_o(fa), .flash_wdata_o(fwd), .flash_timing_o(ftim),
        .flash_rdata_i(frd), .flash_ack_i(fack), .ram_addr_o(ra), .ram_wdata_o(rwd),
        .ram_we_o(rwe), .ram_rdata_i(rrd), .wdt_service_o(wdt), .wdt_lower_en_o(wlo));
    fip_flash_model fm (.clk_i(clk), .cmd_i(fcmd), .addr_i(fa), .wdata_i(fwd),
        .timing_i(ftim), .ram_addr_i(ra),
        .ram_wdata_i(rwd), .ram_we_i(rwe), .rdata_o(frd), .ack_o(fack), .ram_rdata_o(rrd));
    always #10 clk = ~clk;
    // cycle ceiling and pulse counters
    always @(posedge clk) begin
        cyc++;
        irq_n += irqo[2];
        lo_n += wlo;
        wd_n += wdt;
        if (cyc == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    // request held from setup until pready is sampled high
    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
        @(posedge clk);
        psel <= 1;
        pen <= 0;
        pwr <= w;
        pa <= {idx, 2'b00};
        pwd <= {24'h0, d};
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (prdy !== 1'b1);
        r = prd;
        e = perr;
        psel <= 0;
        pen <= 0;
    endtask : apb
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask : wr
    task automatic rd(input logic [9:0] idx);
        apb(1'b0, idx, 8'h00);
    endtask : rd
    task automatic wait_idle();
        do rd(IDX_STATUS); while (r[ST_BUSY] !== 1'b0); // wdt free after return
    endtask : wait_idle
    task automatic t_read();
        rd(IDX_COUNT);
        chk("count reset", {24'h0, REG_RESET}, r);
        wr(IDX_ADDR_HI, 8'h12);
        wr(IDX_ADDR_LO, 8'h34);
        wr(IDX_KEY, UNLOCK_VALUE);
        wr(IDX_CALL, EP_READ_BYTE);
        fork
            wait_idle();
            repeat (2) begin
                @(posedge clk);
                irq <= 8'h04;
                chk("irq block", 1, blk);
                @(posedge clk);
                irq <= 8'h00;
            end
        join
        repeat (3) @(posedge clk);
        chk("flash addr", 16'h1234, fm.last_addr);
        rd(IDX_RESULT);
        chk("result", 32'h26, r);
        chk("irq replay", 1, irq_n);
        chk("lower window", 1, lo_n);
        chk("exit service", 1, wd_n);
        $display("test read done");
    endtask : t_read
    task automatic t_refuse();
        for (int k = 0; k < 4; k++) begin
            if (k == 1) wr(IDX_KEY, 8'h97);
            if (k >= 2) wr(IDX_KEY, UNLOCK_VALUE);
            if (k == 2) begin
                @(posedge clk) irqt <= 1;
                @(posedge clk) irqt <= 0;
            end
            if (k == 3) repeat (4) @(posedge clk);
            wr(IDX_CALL, EP_READ_BYTE);
            rd(IDX_STATUS);
            chk("refused", 32'h4, r & 32'h7);
            wr(IDX_STATUS, 8'h04);
        end
        $display("test refuse done");
    endtask : t_refuse
    task automatic t_erase();
        int n;
        n = fm.ops;
        wr(IDX_ACCUM, 8'h54);
        wr(IDX_KEY, UNLOCK_VALUE);
        wr(IDX_CALL, EP_MASS_ERASE);
        rd(IDX_STATUS);
        chk("bad confirm", 32'h4, r & 32'h7);
        wr(IDX_STATUS, 8'h04);
        wr(IDX_ACCUM, ERASE_CONFIRM);
        wr(IDX_KEY, UNLOCK_VALUE);
        wr(IDX_CALL, EP_MASS_ERASE);
        wait_idle();
        chk("erase ops", n + 1, fm.ops);
        $display("test erase done");
    endtask : t_erase
    task automatic t_secure();
        int n;
        @(posedge clk);
        ser <= 1;
        sec <= 1;
        wr(IDX_CALL, EP_READ_BYTE);
        rd(IDX_STATUS);
        chk("sec block", 32'h8, r & 32'h8);
        wr(IDX_STATUS, 8'h08);
        n = fm.ops;
        wr(IDX_CALL, EP_MASS_ERASE);
        wait_idle();
        chk("sec erase", n + 1, fm.ops);
        ser <= 0;
        wr(IDX_ADDR_LO, 8'h35);
        wr(IDX_KEY, UNLOCK_VALUE);
        wr(IDX_CALL, EP_READ_BYTE);
        wait_idle();
        rd(IDX_RESULT);
        chk("user read", 32'h27, r);
        $display("test secure done");
    endtask : t_secure
    task automatic t_block();
        wr(IDX_ADDR_HI, 8'h30);
        wr(IDX_ADDR_LO, 8'h01);
        wr(IDX_COUNT, 8'h02);
        wr(IDX_XPTR, 8'h10);
        wr(IDX_KEY, UNLOCK_VALUE);
        wr(IDX_CALL, EP_BLOCK_READ);
        wait_idle();
        chk("ram 0", 8'h31, fm.mem[8'h10]);
        chk("ram 1", 8'h32, fm.mem[8'h11]);
        rd(10'h001);
        chk("unmapped err", 1, e);
        chk("unmapped data", 0, r);
        $display("test block done");
    endtask : t_block
    task automatic t_write();
        int n;
        n = fm.ops;
        wr(IDX_TIMING, 8'h5a);
        wr(IDX_ADDR_LO, 8'h40);
        wr(IDX_WVALUE, 8'hc3);
        wr(IDX_KEY, UNLOCK_VALUE);
        wr(IDX_CALL, EP_WRITE_BYTE);
        wait_idle();
        chk("write data", 8'hc3, fm.last_wdata);
        chk("write timing", 8'h5a, fm.last_timing);
        wr(IDX_KEY, UNLOCK_VALUE);
        wr(IDX_CALL, EP_PAGE_ERASE);
        wait_idle();
        wr(IDX_COUNT, 8'h00);
        wr(IDX_KEY, UNLOCK_VALUE);
        wr(IDX_CALL, EP_BLOCK_WRITE);
        wait_idle();
        wr(IDX_COUNT, 8'h02);
        wr(IDX_KEY, UNLOCK_VALUE);
        wr(IDX_CALL, EP_BLOCK_WRITE);
        wait_idle();
        chk("block data", 8'h32, fm.last_wdata);
        chk("block addr", 16'h3041, fm.last_addr);
        chk("write ops", n + 4, fm.ops);
        $display("test write done");
    endtask : t_write
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    // main sequence after five reset cycles
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1;
        repeat (3) @(posedge clk);
        t_read();
        t_refuse();
        t_erase();
        t_secure();
        t_block();
        t_write();
        tally_and_finish();
    end
endmodule : test_flash_isp_call_interface
`default_nettype wire
